// [logic/ssp_spi_port.sv]
// Purpose: spi mode of a synchronous serial port, master or slave
// Assumes: pins synchronous to clk_i; classic wishbone register access
// Notes:   sdo_o trails the shift register by one clock
`timescale 1ns/1ps
`include "ssp_map.svh"

module ssp_spi_port (
	// system
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	// wishbone slave
	input  wire ssp_pkg::ssp_wb_req_s wb_req_i,
	output logic                      wb_ack_o,
	output logic [31:0]               wb_dat_o,
	// serial pins and timer tick
	input  wire logic                 sdi_i,
	input  wire logic                 sck_i,
	input  wire logic                 ss_n_i,
	input  wire logic                 timer_tick_i,
	output logic                      sdo_o,
	output logic                      sdo_oe_o,
	output logic                      sck_o,
	output logic                      sck_oe_o,
	// event
	output logic                      event_flag_o
);

	////////////////////////////////////////////////////////////////////
	// registers and decode

	logic [7:0]          serial_control_one;
	logic [7:0]          serial_control_three;
	logic [7:0]          serial_data_buffer;
	logic [7:0]          rate_reload_reg;
	logic [3:0]          pin_direction_reg;
	logic [1:0]          status_cfg_reg;
	logic                buffer_full_flag;
	logic [7:0]          shift_reg;
	logic                rx_bit_reg;
	logic                pend_reg;
	logic [2:0]          bit_cnt_reg;
	logic [3:0]          tog_cnt_reg;
	ssp_pkg::ssp_state_e state_reg;
	logic [31:0]         rdat_next;

	logic       acc, wr, rd, wr_data, rd_data, wr_ok, start, busy;
	logic       en, clock_idle_level, cke, sample_phase_select, is_master, is_slave, sel_ok;
	logic       slave_act, sdi_eff, sck_act, tick, s_rise, s_fall;
	logic       lead_e, trail_e, sample_e, drive_e, done, ovf_set;
	logic       store, both;
	logic [3:0] mode;
	logic [7:0] wdat, rx_byte;

	// bus request decode
	assign acc     = wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
	assign wr      = acc & wb_req_i.we & wb_req_i.sel[0];
	assign rd      = acc & ~wb_req_i.we;
	assign wdat    = wb_req_i.dat[7:0];
	assign wr_data = wr & (wb_req_i.adr == `SSP_ADR_DATA);
	assign rd_data = rd & (wb_req_i.adr == `SSP_ADR_DATA);

	// configuration fields
	assign en   = serial_control_one[`SSP_C1_EN];
	assign clock_idle_level  = serial_control_one[`SSP_C1_CKP];
	assign mode = serial_control_one[3:0];
	assign cke  = status_cfg_reg[0];
	assign sample_phase_select  = status_cfg_reg[1];
	assign is_master = (mode == `SSP_MODE_M4) | (mode == `SSP_MODE_M16) |
		(mode == `SSP_MODE_M64) | (mode == `SSP_MODE_MTMR) |
		(mode == `SSP_MODE_MRLD);
	assign is_slave = (mode == `SSP_MODE_SSS) | (mode == `SSP_MODE_SLV);

	// slave select, honoured only in select mode
	assign sel_ok = (mode != `SSP_MODE_SSS) |
		(pin_direction_reg[`SSP_DIR_SS] & ~ss_n_i);
	assign slave_act = en & is_slave & sel_ok;

	// inputs masked by their direction bits
	assign sdi_eff = sdi_i & pin_direction_reg[`SSP_DIR_SDI];
	assign sck_act = (pin_direction_reg[`SSP_DIR_SCK] ? sck_i : clock_idle_level) ^ clock_idle_level;

	// transfer in progress, write acceptance
	assign busy  = (state_reg == ssp_pkg::SSP_MRUN) | (bit_cnt_reg != 3'h0)
		| pend_reg;
	assign wr_ok = wr_data & ~busy & ~serial_control_one[`SSP_C1_WRITE_COLLISION_FLAG];
	assign start = wr_ok & en & is_master;

	////////////////////////////////////////////////////////////////////
	// clock edges

	ssp_rate_gen u_rate (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.run_i        (state_reg == ssp_pkg::SSP_MRUN),
		.mode_i       (mode),
		.reload_i     (rate_reload_reg),
		.timer_tick_i (timer_tick_i),
		.tick_o       (tick)
	);

	ssp_edge_det u_edge (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.level_i (sck_act),
		.rise_o  (s_rise),
		.fall_o  (s_fall)
	);

	// leading edge leaves idle, trailing edge returns to it
	assign lead_e  = (tick & (sck_o == clock_idle_level) & (state_reg ==
		ssp_pkg::SSP_MRUN)) | (s_rise & slave_act);
	assign trail_e = (tick & (sck_o != clock_idle_level) & (state_reg ==
		ssp_pkg::SSP_MRUN)) | (s_fall & slave_act);

	// edge roles from edge select and sample phase
	assign both     = sample_phase_select & cke & is_master;
	assign drive_e  = cke ? trail_e : lead_e;
	assign sample_e = (cke & ~both) ? lead_e : trail_e;
	assign done     = sample_e & (bit_cnt_reg == `SSP_LAST_BIT);
	assign rx_byte  = {shift_reg[6:0], sdi_eff};
	assign ovf_set  = done & buffer_full_flag & ~rd_data &
		~serial_control_three[`SSP_C3_BOEN];
	assign store    = done & ~ovf_set;

	////////////////////////////////////////////////////////////////////
	// master clocking state

	// run sixteen half periods per byte
	always_ff @(posedge clk_i) begin
		if (rst_i || !en) begin
			state_reg   <= ssp_pkg::SSP_IDLE;
			tog_cnt_reg <= 4'h0;
		end else begin
			case (state_reg)
				ssp_pkg::SSP_IDLE: begin
					tog_cnt_reg <= 4'h0;
					if (start)
						state_reg <= ssp_pkg::SSP_MRUN;
				end
				ssp_pkg::SSP_MRUN: begin
					if (tick) begin
						tog_cnt_reg <= tog_cnt_reg + 4'h1;
						if (tog_cnt_reg == `SSP_LAST_TOG)
							state_reg <= ssp_pkg::SSP_IDLE;
					end
				end
				default: state_reg <= ssp_pkg::SSP_IDLE;
			endcase
		end
	end

	// serial clock output, idle at the polarity level
	always_ff @(posedge clk_i) begin
		if (rst_i)
			sck_o <= 1'b0;
		else if (state_reg != ssp_pkg::SSP_MRUN)
			sck_o <= clock_idle_level;
		else if (tick)
			sck_o <= ~sck_o;
	end

	////////////////////////////////////////////////////////////////////
	// shift engine

	// shift out msb, collect lsb, count bits
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			shift_reg   <= `SSP_RST_BYTE;
			rx_bit_reg  <= 1'b0;
			pend_reg    <= 1'b0;
			bit_cnt_reg <= 3'h0;
		end else if (wr_ok) begin
			shift_reg   <= wdat;
			pend_reg    <= 1'b0;
			bit_cnt_reg <= 3'h0;
		end else if (!en || (is_slave && !sel_ok)) begin
			pend_reg    <= 1'b0;
			bit_cnt_reg <= 3'h0;
		end else if (sample_e) begin
			if (drive_e || done)
				shift_reg <= rx_byte;
			else begin
				rx_bit_reg <= sdi_eff;
				pend_reg   <= 1'b1;
			end
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
		end else if (drive_e && pend_reg) begin
			shift_reg <= {shift_reg[6:0], rx_bit_reg};
			pend_reg  <= 1'b0;
		end
	end

	// pins follow the shift register and the enables
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sdo_o    <= 1'b0;
			sdo_oe_o <= 1'b0;
			sck_oe_o <= 1'b0;
		end else begin
			sdo_o    <= shift_reg[7];
			sdo_oe_o <= ~pin_direction_reg[`SSP_DIR_SDO] &
				((en & is_master) | slave_act);
			sck_oe_o <= en & is_master &
				~pin_direction_reg[`SSP_DIR_SCK];
		end
	end

	////////////////////////////////////////////////////////////////////
	// software registers

	// control one, collision and overflow set by hardware
	always_ff @(posedge clk_i) begin
		if (rst_i)
			serial_control_one <= `SSP_RST_BYTE;
		else begin
			if (wr && wb_req_i.adr == `SSP_ADR_CTRL1)
				serial_control_one <= wdat;
			if (wr_data && busy)
				serial_control_one[`SSP_C1_WRITE_COLLISION_FLAG] <= 1'b1;
			if (ovf_set)
				serial_control_one[`SSP_C1_OVF] <= 1'b1;
		end
	end

	// plain configuration registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			serial_control_three <= `SSP_RST_BYTE;
			rate_reload_reg      <= `SSP_RST_BYTE;
			pin_direction_reg    <= `SSP_RST_DIR;
			status_cfg_reg       <= 2'h0;
		end else if (wr) begin
			case (wb_req_i.adr)
				`SSP_ADR_CTRL3:  serial_control_three <= wdat;
				`SSP_ADR_RELOAD: rate_reload_reg <= wdat;
				`SSP_ADR_PINDIR: pin_direction_reg <= wdat[3:0];
				`SSP_ADR_STATUS: status_cfg_reg <= wdat[7:6];
				default: ;
			endcase
		end
	end

	// data buffer and full flag; load wins over read
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			serial_data_buffer <= `SSP_RST_BYTE;
			buffer_full_flag   <= 1'b0;
		end else begin
			if (wr_ok)
				serial_data_buffer <= wdat;
			if (rd_data)
				buffer_full_flag <= 1'b0;
			if (store) begin
				serial_data_buffer <= rx_byte;
				buffer_full_flag   <= 1'b1;
			end
		end
	end

	// event flag, write one clears, new byte wins
	always_ff @(posedge clk_i) begin
		if (rst_i)
			event_flag_o <= 1'b0;
		else if (store)
			event_flag_o <= 1'b1;
		else if (wr && wb_req_i.adr == `SSP_ADR_EVENT && wdat[0])
			event_flag_o <= 1'b0;
	end

	// read data select; shift register has no address
	always_comb begin
		case (wb_req_i.adr)
			`SSP_ADR_STATUS: rdat_next = {24'h000000, status_cfg_reg,
				5'h00, buffer_full_flag};
			`SSP_ADR_CTRL1:  rdat_next = {24'h000000, serial_control_one};
			`SSP_ADR_CTRL3:  rdat_next = {24'h000000, serial_control_three};
			`SSP_ADR_DATA:   rdat_next = {24'h000000, serial_data_buffer};
			`SSP_ADR_RELOAD: rdat_next = {24'h000000, rate_reload_reg};
			`SSP_ADR_PINDIR: rdat_next = {28'h0000000, pin_direction_reg};
			`SSP_ADR_EVENT:  rdat_next = {31'h00000000, event_flag_o};
			default:         rdat_next = 32'h00000000;
		endcase
	end

	// one-wait answer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= acc;
			if (rd)
				wb_dat_o <= rdat_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_start;
		start;
	endsequence

	sequence s_run8;
		(state_reg == ssp_pkg::SSP_MRUN || !en)[*8];
	endsequence

	a_master_byte_runs: assert property (s_start |=> s_run8)
		else $error("master exchange did not start");

	a_byte_to_buffer: assert property (store |=> buffer_full_flag &&
		serial_data_buffer == $past(rx_byte))
		else $error("received byte not buffered");

	a_write_loads_both: assert property (wr_ok |=> shift_reg ==
		$past(wdat) && serial_data_buffer == $past(wdat))
		else $error("write did not load buffer and shifter");

	a_busy_write_drop: assert property (wr_data && busy |=>
		serial_control_one[`SSP_C1_WRITE_COLLISION_FLAG] &&
		$stable(serial_data_buffer))
		else $error("busy write not discarded");

	a_read_clears_full: assert property (rd_data && !store |=>
		!buffer_full_flag)
		else $error("buffer full not cleared by read");

	a_disable_idle: assert property (!en |=> state_reg ==
		ssp_pkg::SSP_IDLE && bit_cnt_reg == 3'h0)
		else $error("disabled port not idle");

	a_deselect_quiet: assert property (en && mode == `SSP_MODE_SSS &&
		!sel_ok |=> !sdo_oe_o && bit_cnt_reg == 3'h0)
		else $error("deselected slave still active");

	a_sck_idle_level: assert property ((state_reg ==
		ssp_pkg::SSP_IDLE)[*2] |-> sck_o == $past(clock_idle_level))
		else $error("serial clock not at idle level");

	a_msb_first: assert property (done && !wr_ok |=> shift_reg ==
		{$past(shift_reg[6:0]), $past(sdi_eff)})
		else $error("last bit not shifted into lsb");

endmodule // ssp_spi_port

// [logic/ssp_map.svh]
// Purpose: register offsets, field positions, reset values and counts
// Assumes: byte addresses on a 32-bit classic Wishbone bus
// Notes:   included by its bare name
`ifndef SSP_MAP_SVH
`define SSP_MAP_SVH

// register byte offsets
`define SSP_ADR_STATUS 8'h00
`define SSP_ADR_CTRL1  8'h04
`define SSP_ADR_CTRL3  8'h08
`define SSP_ADR_DATA   8'h0C
`define SSP_ADR_RELOAD 8'h10
`define SSP_ADR_PINDIR 8'h14
`define SSP_ADR_EVENT  8'h18

// status fields
`define SSP_ST_SMP 7
`define SSP_ST_CKE 6
`define SSP_ST_BF  0

// control one fields
`define SSP_C1_WRITE_COLLISION_FLAG 7
`define SSP_C1_OVF  6
`define SSP_C1_EN   5
`define SSP_C1_CKP  4

// control three fields
`define SSP_C3_BOEN 4

// pin direction bits, set means input
`define SSP_DIR_SDI 0
`define SSP_DIR_SDO 1
`define SSP_DIR_SCK 2
`define SSP_DIR_SS  3

// mode codes in control one bits 3..0
`define SSP_MODE_M4   4'h0
`define SSP_MODE_M16  4'h1
`define SSP_MODE_M64  4'h2
`define SSP_MODE_MTMR 4'h3
`define SSP_MODE_SSS  4'h4
`define SSP_MODE_SLV  4'h5
`define SSP_MODE_MRLD 4'hA

// half serial clock periods minus one, in system clocks
`define SSP_HALF4  10'h001
`define SSP_HALF16 10'h007
`define SSP_HALF64 10'h01F

// reset values and counts
`define SSP_RST_BYTE 8'h00
`define SSP_RST_DIR  4'hF
`define SSP_LAST_BIT 3'h7
`define SSP_LAST_TOG 4'hF

`endif

// [logic/ssp_pkg.sv]
// Purpose: shared types of the serial port
// Assumes: nothing
// Notes:   constants live in ssp_map.svh
package ssp_pkg;

	// one classic wishbone request
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} ssp_wb_req_s;

	// master clocking state
	typedef enum logic [1:0] {
		SSP_IDLE,
		SSP_MRUN
	} ssp_state_e;

endpackage

// [logic/ssp_rate_gen.sv]
// Purpose: half-period tick generator for the master serial clock
// Assumes: run_i high only while a master byte is clocked
// Notes:   tick_o is a one-cycle pulse per serial clock edge
`timescale 1ns/1ps
`include "ssp_map.svh"

module ssp_rate_gen (
	// system
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// control
	input  wire logic       run_i,
	input  wire logic [3:0] mode_i,
	input  wire logic [7:0] reload_i,
	input  wire logic       timer_tick_i,
	// tick out
	output logic            tick_o
);

	logic [9:0] cnt_reg;
	logic [9:0] limit;

	// half period length per clock rate option
	always_comb begin
		case (mode_i)
			`SSP_MODE_M4:   limit = `SSP_HALF4;
			`SSP_MODE_M16:  limit = `SSP_HALF16;
			`SSP_MODE_M64:  limit = `SSP_HALF64;
			`SSP_MODE_MRLD: limit = {1'b0, reload_i, 1'b1};
			default:        limit = `SSP_HALF4;
		endcase
	end

	// count system clocks, or pass the timer pulse through
	always_ff @(posedge clk_i) begin
		if (rst_i || !run_i) begin
			cnt_reg <= 10'h000;
			tick_o  <= 1'b0;
		end else if (mode_i == `SSP_MODE_MTMR) begin
			tick_o  <= timer_tick_i;
		end else if (cnt_reg >= limit) begin
			cnt_reg <= 10'h000;
			tick_o  <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 10'h001;
			tick_o  <= 1'b0;
		end
	end

endmodule // ssp_rate_gen

// [logic/ssp_edge_det.sv]
// Purpose: edge finder for a level already synchronous to clk_i
// Assumes: level_i idles low
// Notes:   outputs are one-cycle pulses
`timescale 1ns/1ps

module ssp_edge_det (
	// system
	input  wire logic clk_i,
	input  wire logic rst_i,
	// level in
	input  wire logic level_i,
	// edges out
	output logic      rise_o,
	output logic      fall_o
);

	logic prev_reg;

	// previous level
	always_ff @(posedge clk_i) begin
		if (rst_i)
			prev_reg <= 1'b0;
		else
			prev_reg <= level_i;
	end

	// edge pulses
	assign rise_o = level_i & ~prev_reg;
	assign fall_o = ~level_i & prev_reg;

endmodule // ssp_edge_det

// [testbench/ssp_far_end.sv]
// Purpose: far-side spi peer, slave or master role
// Assumes: pins seen in the clk_i domain; cke_i picks the edge roles
// Notes:   cke low drives leading, captures trailing; high the reverse
`timescale 1ns/1ps

module ssp_far_end (
	// system
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// control
	input  wire logic       role_i,
	input  wire logic       idle_i,
	input  wire logic       cke_i,
	input  wire logic       sel_i,
	input  wire logic       go_i,
	input  wire logic [7:0] tx_i,
	// pins
	input  wire logic       sdo_i,
	input  wire logic       sck_i,
	output logic            sdi_o,
	output logic            sck_o,
	// result
	output logic [7:0]      rx_o,
	output logic            done_o
);
	logic       busy;
	logic       sck_d;
	logic [1:0] dv;
	logic [4:0] n;
	logic       sck_w;
	logic       act;
	assign sck_w = role_i ? sck_o : sck_i;
	assign act = role_i ? (busy | done_o) : sel_i;

	// clock maker, shifter and idle noise on the data line
	always_ff @(posedge clk_i) begin
		done_o <= 1'b0;
		sck_d  <= sck_w;
		if (rst_i) begin
			busy  <= 1'b0;
			sck_o <= 1'b0;
			sdi_o <= 1'b0;
		end else if (go_i) begin
			rx_o  <= tx_i;
			sdi_o <= tx_i[7];
			n     <= 5'h00;
			dv    <= 2'h0;
			busy  <= role_i;
			sck_o <= idle_i;
		end else begin
			if (role_i && busy) begin
				dv <= dv + 2'h1;
				if (dv == 2'h3) begin
					sck_o <= ~sck_o;
					n     <= n + 5'h01;
					if (n == 5'h0F) begin
						busy   <= 1'b0;
						done_o <= 1'b1;
					end
				end
			end
			if (!act) begin
				sdi_o <= ~sdi_o;
			end else if (sck_w != sck_d) begin
				if ((sck_d == idle_i) ^ cke_i) begin
					sdi_o <= rx_o[7];
				end else begin
					rx_o <= {rx_o[6:0], sdo_i};
				end
			end
		end
	end
endmodule // ssp_far_end

// [testbench/test_ssp_spi_port.sv]
// Purpose: self-checking bench of the spi port
// Assumes: classic wishbone master, far-side peer model
// Notes:   rows first, then serial scenarios
`timescale 1ns/1ps
`include "ssp_map.svh"

module test_ssp_spi_port;
	localparam logic [7:0] ST = `SSP_ADR_STATUS;
	localparam logic [7:0] C1 = `SSP_ADR_CTRL1;
	localparam logic [7:0] C3 = `SSP_ADR_CTRL3;
	localparam logic [7:0] DB = `SSP_ADR_DATA;
	localparam logic [7:0] RL = `SSP_ADR_RELOAD;
	localparam logic [7:0] PD = `SSP_ADR_PINDIR;
	localparam logic [7:0] EV = `SSP_ADR_EVENT;
	typedef struct packed {
		logic       w;
		logic [7:0] a;
		logic [3:0] s;
		logic [7:0] d;
	} ssp_row_s;
	ssp_pkg::ssp_wb_req_s req;
	logic        clk_i, rst_i, ack, sdo, sdo_oe, sck, sck_oe, evt;
	logic        ss_n, tick, tg, role, go, idle, psdi, psck, pdone;
	logic        sck_q, cke;
	logic [31:0] rdat, rd;
	logic [7:0]  ptx, prx, c;
	int          n_fail, compares, cyc, n, gap, last_t;
	ssp_row_s    rows [12];
	int          mt [5][2];

	ssp_spi_port i_ssp_spi_port (.clk_i(clk_i), .rst_i(rst_i),
		.wb_req_i(req), .wb_ack_o(ack), .wb_dat_o(rdat), .sdi_i(psdi),
		.sck_i(psck), .ss_n_i(ss_n), .timer_tick_i(tick), .sdo_o(sdo),
		.sdo_oe_o(sdo_oe), .sck_o(sck), .sck_oe_o(sck_oe),
		.event_flag_o(evt));
	ssp_far_end i_ssp_far_end (.clk_i(clk_i), .rst_i(rst_i),
		.role_i(role), .idle_i(idle), .cke_i(cke), .sel_i(1'b1), .go_i(go),
		.tx_i(ptx), .sdo_i(sdo_oe ? sdo : tg),
		.sck_i(sck_oe ? sck : idle), .sdi_o(psdi), .sck_o(psck),
		.rx_o(prx), .done_o(pdone));

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			n_fail++;
			$display("unexpected at %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [3:0] s, input logic [7:0] d);
		@(posedge clk_i);
		req <= '{1'b1, 1'b1, w, a, s, {24'h000000, d}};
		do @(posedge clk_i); while (ack !== 1'b1);
		rd = rdat;
		req <= '0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		wb(1'b0, a, 4'hF, 8'h00);
		chk(rd, {24'h000000, e});
	endtask
	task automatic pulse_go(input logic [7:0] t);
		ptx <= t;
		go  <= 1'b1;
		@(posedge clk_i);
		go  <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wait_sig(input int which);
		n = 0;
		while (((which == 0) ? evt : pdone) !== 1'b1 && n < 3000) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 3000) n_fail++;
		repeat (3) @(posedge clk_i);
	endtask
	task automatic end_of_test;
		if (n_fail == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// clock
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	// timer ticks, idle noise, timeout and sck gap meter
	always @(posedge clk_i) begin
		tg    <= ~tg;
		cyc   <= cyc + 1;
		tick  <= (cyc % 5 == 4);
		sck_q <= sck;
		if (sck !== sck_q) begin
			gap    <= cyc - last_t;
			last_t <= cyc;
		end
		if (cyc == 30000) begin
			n_fail++;
			end_of_test();
		end
	end

	//////////////////////////////////////////////////////////////////////
	initial begin
		req = '0; rst_i = 1'b1; ss_n = 1'b1; tick = 1'b0; tg = 1'b0;
		role = 1'b0; go = 1'b0; idle = 1'b0; ptx = 8'h00; cyc = 0;
		last_t = 0; gap = 0; n_fail = 0; compares = 0; cke = 1'b0;
		rows = '{'{0, PD, 4'hF, 8'h0F}, '{0, ST, 4'hF, 8'h00},
			'{1, ST, 4'hF, 8'hFF}, '{0, ST, 4'hF, 8'hC0},
			'{1, C1, 4'hF, 8'h3F}, '{0, C1, 4'hF, 8'h3F},
			'{1, C3, 4'hF, 8'h10}, '{0, C3, 4'hF, 8'h10},
			'{1, RL, 4'hF, 8'hA5}, '{1, RL, 4'h0, 8'h3C},
			'{0, RL, 4'hF, 8'hA5}, '{0, 8'h1C, 4'hF, 8'h00}};
		mt = '{'{32'h20, 2}, '{32'h21, 8}, '{32'h22, 32},
			'{32'h23, 5}, '{32'h3A, 4}};
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk({ack, sdo_oe, sck_oe, evt, sck}, 0);
		// register rows
		for (int i = 0; i < 12; i++) begin
			wb(rows[i].w, rows[i].a, rows[i].s, rows[i].d);
			if (!rows[i].w) chk(rd, {24'h000000, rows[i].d});
		end
		wb(1'b1, ST, 4'hF, 8'h00);
		wb(1'b1, C3, 4'hF, 8'h00);
		wb(1'b1, RL, 4'hF, 8'h01);
		wb(1'b1, PD, 4'hF, 8'h09);
		// master exchange at every clock rate, with a collision
		for (int k = 0; k < 5; k++) begin
			c = mt[k][0];
			idle <= c[4];
			wb(1'b1, C1, 4'hF, c);
			pulse_go(8'h3C ^ k);
			chk({sck, sck_oe}, {c[4], 1'b1});
			wb(1'b1, DB, 4'hF, 8'hA5 ^ k);
			wb(1'b1, DB, 4'hF, 8'h00);
			wait_sig(0);
			chk(evt, 1'b1);
			chk(gap, mt[k][1]);
			rdc(ST, 8'h01);
			rdc(C1, 8'h80 | c);
			rdc(DB, 8'h3C ^ k);
			rdc(ST, 8'h00);
			chk(prx, 8'hA5 ^ k);
			wb(1'b1, EV, 4'hF, 8'h01);
		end
		// master with sample on leading, drive on trailing edge
		idle <= 1'b0;
		cke  <= 1'b1;
		wb(1'b1, ST, 4'hF, 8'h40);
		wb(1'b1, C1, 4'hF, 8'h20);
		pulse_go(8'hE7);
		wb(1'b1, DB, 4'hF, 8'h18);
		wait_sig(0);
		rdc(ST, 8'h41);
		rdc(DB, 8'hE7);
		chk(prx, 8'h18);
		wb(1'b1, EV, 4'hF, 8'h01);
		wb(1'b1, ST, 4'hF, 8'h00);
		cke <= 1'b0;
		// slave: ignored while disabled, then a whole byte
		wb(1'b1, C1, 4'hF, 8'h05);
		wb(1'b1, PD, 4'hF, 8'h0D);
		wb(1'b1, DB, 4'hF, 8'h5A);
		role <= 1'b1;
		idle <= 1'b0;
		pulse_go(8'hC3);
		wait_sig(1);
		chk(evt, 1'b0);
		wb(1'b1, C1, 4'hF, 8'h25);
		pulse_go(8'hC3);
		wait_sig(1);
		chk(evt, 1'b1);
		chk(prx, 8'h5A);
		rdc(DB, 8'hC3);
		// slave select mode: deselected, then selected
		wb(1'b1, EV, 4'hF, 8'h01);
		wb(1'b1, C1, 4'hF, 8'h24);
		wb(1'b1, DB, 4'hF, 8'h96);
		chk(sdo_oe, 1'b0);
		pulse_go(8'h0F);
		wait_sig(1);
		chk(evt, 1'b0);
		ss_n <= 1'b0;
		pulse_go(8'h71);
		chk(sdo_oe, 1'b1);
		wait_sig(1);
		chk(prx, 8'h96);
		rdc(DB, 8'h71);
		wb(1'b1, PD, 4'hF, 8'h0F);
		@(posedge clk_i);
		chk(sdo_oe, 1'b0);
		end_of_test();
	end
endmodule // test_ssp_spi_port
